//--- core/ind_ptr_pkg.sv
// constants and carriers for the core register slice
// assumes one 10 MHz clock shared with the instruction datapath
package ind_ptr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // special-register addresses in data memory
  localparam logic [11:0] ADR_STACK_TOP_UPPER   = 12'hFFF;
  localparam logic [11:0] ADR_STACK_TOP_HIGH    = 12'hFFE;
  localparam logic [11:0] ADR_STACK_TOP_LOW     = 12'hFFD;
  localparam logic [11:0] ADR_RETURN_STACK_IDX  = 12'hFFC;
  localparam logic [11:0] ADR_PC_UPPER_HOLD     = 12'hFFB;
  localparam logic [11:0] ADR_PC_HIGH_HOLD      = 12'hFFA;
  localparam logic [11:0] ADR_PC_LOW_BYTE       = 12'hFF9;
  localparam logic [11:0] ADR_TABLE_PTR_UPPER   = 12'hFF8;
  localparam logic [11:0] ADR_TABLE_PTR_HIGH    = 12'hFF7;
  localparam logic [11:0] ADR_TABLE_PTR_LOW     = 12'hFF6;
  localparam logic [11:0] ADR_TABLE_READ_LATCH  = 12'hFF5;
  localparam logic [11:0] ADR_MULT_RESULT_HIGH  = 12'hFF4;
  localparam logic [11:0] ADR_MULT_RESULT_LOW   = 12'hFF3;
  localparam logic [11:0] ADR_INT_CTRL_MAIN     = 12'hFF2;
  localparam logic [11:0] ADR_INT_CTRL_SECOND   = 12'hFF1;
  localparam logic [11:0] ADR_INT_CTRL_THIRD    = 12'hFF0;
  localparam logic [11:0] ADR_IND_PLAIN         = 12'hFEF;
  localparam logic [11:0] ADR_IND_AFTER_UP      = 12'hFEE;
  localparam logic [11:0] ADR_IND_AFTER_DOWN    = 12'hFED;
  localparam logic [11:0] ADR_IND_BEFORE_UP     = 12'hFEC;
  localparam logic [11:0] ADR_IND_ACC_OFFSET    = 12'hFEB;
  localparam logic [11:0] ADR_POINTER_ZERO_HIGH = 12'hFEA;
  localparam logic [11:0] ADR_POINTER_ZERO_LOW  = 12'hFE9;
  localparam logic [11:0] ADR_WORKING_ACC       = 12'hFE8;
  localparam logic [11:0] ADR_BANK_SELECT       = 12'hFE0;
  // lowest special-register address; below it is general RAM
  localparam logic [11:0] ADR_SFR_BASE          = 12'hF60;
  localparam int          RAM_WORDS             = 3936;
  // reset values and implemented-bit masks
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_INT_SECOND   = 8'hFF;
  localparam logic [7:0] RST_INT_THIRD    = 8'hC0;
  localparam logic [7:0] MASK_UPPER5      = 8'h1F;
  localparam logic [7:0] MASK_UPPER6      = 8'h3F;
  localparam logic [7:0] MASK_STACK_IDX   = 8'hDF;
  localparam logic [7:0] MASK_NIBBLE      = 8'h0F;
  localparam logic [11:0] PTR_STEP        = 12'h001;

  typedef enum logic [2:0] {
    IND_NONE   = 3'b000,
    IND_PLAIN  = 3'b001,
    IND_UP     = 3'b010,
    IND_DOWN   = 3'b011,
    IND_PRE    = 3'b100,
    IND_OFFSET = 3'b101
  } ind_mode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } file_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } file_rsp_t;
endpackage

//--- core/indirect_pointer_operand_access.sv
// register file slice: general RAM, core registers, pointer-zero indirection
// peripheral registers live elsewhere and read zero through this slice
// assumes the datapath issues one access per cycle on clock, srst synchronous
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: plain location uses pointer, leaves it
// RQ2: after-up uses pointer, then adds one
// RQ3: after-down uses pointer, then subtracts one
// RQ4: before-up adds one, then uses it
// RQ5: offset location addresses pointer plus accumulator
// RQ6: indirect locations store nothing, redirect unless the pointer aims at one
// RQ7: unimplemented locations read as zero
// RQ8: pointer holds twelve-bit address, no banking
// RQ9: pointer wraps; one update per access
module indirect_pointer_operand_access (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   srst,
  // register file access from the datapath
  input  wire ind_ptr_pkg::file_req_t req,
  output var  ind_ptr_pkg::file_rsp_t rsp,
  // state visible to the core
  output var  logic [11:0]            pointerZero,
  output var  logic [7:0]             workingAcc,
  output var  logic [3:0]             bankSelect
);
  import ind_ptr_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // general RAM has no reset; contents survive srst
  logic [7:0]  ram [RAM_WORDS];
  logic [7:0]  coreReg_q [16];
  logic [11:0] ptr_q;
  logic [11:0] ptr_d;
  logic [7:0]  acc_q;
  logic [3:0]  bank_q;
  file_rsp_t   rsp_q;

  function automatic logic [7:0] reset_of(input logic [3:0] idx);
    unique case (idx)
      4'h1:    reset_of = RST_INT_SECOND;
      4'h0:    reset_of = RST_INT_THIRD;
      default: reset_of = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] mask_of(input logic [3:0] idx);
    unique case (idx)
      4'hF, 4'hB: mask_of = MASK_UPPER5 | 8'h20;
      4'h8:       mask_of = MASK_UPPER6;
      4'hC:       mask_of = MASK_STACK_IDX;
      default:    mask_of = 8'hFF;
    endcase
  endfunction

  // the five indirect locations sit in one contiguous run
  function automatic logic is_ind_loc(input logic [11:0] a);
    is_ind_loc = (a <= ADR_IND_PLAIN) && (a >= ADR_IND_ACC_OFFSET);
  endfunction

  // one step either way; twelve-bit wrap is wanted, no carry out
  // shared by the after-up, after-down and before-up paths
  function automatic logic [11:0] ptr_step(input logic [11:0] p, input logic down);
    ptr_step = down ? (p - PTR_STEP) : (p + PTR_STEP);
  endfunction

  // ---------------------------------------------------------------
  // indirect decode
  // ---------------------------------------------------------------
  // direct addresses pass straight through; only the five
  // indirect codes are rewritten from the pointer
  wire       acc      = req.rd | req.wr;
  ind_mode_t mode;
  assign mode = !acc                         ? IND_NONE   :
                req.addr == ADR_IND_PLAIN      ? IND_PLAIN  :
                req.addr == ADR_IND_AFTER_UP   ? IND_UP     :
                req.addr == ADR_IND_AFTER_DOWN ? IND_DOWN   :
                req.addr == ADR_IND_BEFORE_UP  ? IND_PRE    :
                req.addr == ADR_IND_ACC_OFFSET ? IND_OFFSET : IND_NONE;
  wire isInd = mode != IND_NONE;

  // RQ4 pre-increment address
  wire [11:0] ptrPlus  = ptr_step(ptr_q, 1'b0);
  // RQ9 wraps within twelve bits
  wire [11:0] ptrMinus = ptr_step(ptr_q, 1'b1);
  // RQ5 pointer plus accumulator
  // accumulator is zero-extended, never sign-extended
  wire [11:0] ptrOff   = ptr_q + {4'h0, acc_q};

  // RQ1 RQ2 RQ3 RQ8 effective address
  wire [11:0] effAddr = (mode == IND_PRE)    ? ptrPlus :
                        (mode == IND_OFFSET) ? ptrOff  :
                        isInd                ? ptr_q   : req.addr;

  // ---------------------------------------------------------------
  // address classes
  // ---------------------------------------------------------------
  // a pointer that aims at an indirect location reads zero, writes nothing;
  // chaining one redirection into another would need a second address stage
  wire effInd  = is_ind_loc(effAddr);
  wire dropInd = isInd && effInd;
  wire isRam   = effAddr < ADR_SFR_BASE;
  // 0xF60-0xFDF belong to other peripherals and read zero here
  wire isCore = effAddr >= ADR_INT_CTRL_THIRD;
  wire [3:0] coreIdx = effAddr[3:0];
  wire isPhi  = effAddr == ADR_POINTER_ZERO_HIGH;
  wire isPlo  = effAddr == ADR_POINTER_ZERO_LOW;
  wire isAcc  = effAddr == ADR_WORKING_ACC;
  wire isBank = effAddr == ADR_BANK_SELECT;
  // RQ6 no storage behind indirect locations
  // writes to unimplemented addresses land nowhere and are not flagged
  wire wrEn   = req.wr && !dropInd;

  // RQ7 unimplemented locations read zero
  wire [7:0] rdMux = dropInd ? RST_ZERO :
                     isRam  ? ram[effAddr] :
                     isCore ? coreReg_q[coreIdx] :
                     isPhi  ? {4'h0, ptr_q[11:8]} :
                     isPlo  ? ptr_q[7:0] :
                     isAcc  ? acc_q :
                     isBank ? {4'h0, bank_q} : RST_ZERO;

  // ---------------------------------------------------------------
  // pointer update
  // ---------------------------------------------------------------
  // every step starts from the pointer as it stood before this access
  always_comb begin
    ptr_d = ptr_q;
    // RQ9 one update, direct write wins
    if (wrEn && isPhi) begin
      ptr_d = {req.wdata[3:0], ptr_q[7:0]};
    end else if (wrEn && isPlo) begin
      ptr_d = {ptr_q[11:8], req.wdata};
    end else begin
      unique case (mode)
        // RQ2 post-increment
        IND_UP:   ptr_d = ptrPlus;
        // RQ3 post-decrement
        IND_DOWN: ptr_d = ptrMinus;
        // RQ4 pre-increment keeps the new value
        IND_PRE:  ptr_d = ptrPlus;
        // RQ1 plain and offset leave it
        IND_NONE, IND_PLAIN, IND_OFFSET: ptr_d = ptr_q;
        default:  ptr_d = ptr_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (wrEn && isRam) begin
      ram[effAddr] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        coreReg_q[i] <= reset_of(4'(i));
      end
    end else if (wrEn && isCore) begin
      // masked bits stay zero, so reads need no second mask
      coreReg_q[coreIdx] <= req.wdata & mask_of(coreIdx);
    end
  end

  // RQ9 one update per access
  // reset aims the first indirect access after srst at address zero, or at address one for before-up
  always_ff @(posedge clock) begin
    if (srst) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ---------------------------------------------------------------
  // accumulator and bank select
  // ---------------------------------------------------------------
  // bank select is only held for the core; no address here uses it
  // the accumulator feeds the offset mode as it stood before the access
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q  <= RST_ZERO;
      bank_q <= RST_ZERO[3:0];
    end else begin
      if (wrEn && isAcc) begin
        acc_q <= req.wdata;
      end
      if (wrEn && isBank) begin
        bank_q <= req.wdata[3:0] & MASK_NIBBLE[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read response
  // ---------------------------------------------------------------
  // registered, so the answer stands the cycle after the read;
  // a combined read and write returns the old contents
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= req.rd;
      rsp_q.rdata <= req.rd ? rdMux : RST_ZERO;
    end
  end

  assign rsp         = rsp_q;
  assign pointerZero = ptr_q;
  assign workingAcc  = acc_q;
  assign bankSelect  = bank_q;
endmodule // indirect_pointer_operand_access

`default_nettype wire

//--- tb/ind_ptr_properties.sv
// assertions on the register slice ports
// bound onto the register slice module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ind_ptr_properties (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   srst,
  // access and state
  input wire ind_ptr_pkg::file_req_t req,
  input wire ind_ptr_pkg::file_rsp_t rsp,
  input wire logic [11:0]            pointerZero,
  input wire logic [7:0]             workingAcc,
  input wire logic [3:0]             bankSelect
);
  import ind_ptr_pkg::*;
  // ---------------------------------
  // properties
  // ---------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence readOf(logic [11:0] a);
    req.rd && !req.wr && req.addr == a;
  endsequence
  // pointer moves by d after a pure read of a
  property moved(logic [11:0] a, logic [11:0] d);
    readOf(a) |=> pointerZero == $past(pointerZero) + d;
  endproperty
  AST_PLAIN: assert property (moved(ADR_IND_PLAIN, 12'h000))
    else $error("plain read moved pointer");
  AST_UP: assert property (moved(ADR_IND_AFTER_UP, 12'h001))
    else $error("after-up step wrong");
  AST_DOWN: assert property (moved(ADR_IND_AFTER_DOWN, 12'hFFF))
    else $error("after-down step wrong");
  AST_PRE: assert property (moved(ADR_IND_BEFORE_UP, 12'h001))
    else $error("before-up step wrong");
  AST_ZERO: assert property (req.rd && req.addr >= ADR_SFR_BASE
    && req.addr < ADR_BANK_SELECT |=> rsp.rdata == 8'h00) else $error("unused not zero");
  AST_HOLD: assert property (!req.rd && !req.wr |=> $stable(pointerZero))
    else $error("pointer moved while idle");
  AST_VALID: assert property (req.rd |=> rsp.valid)
    else $error("read not answered");
  AST_ECHO: assert property (rsp.valid |-> $past(req.rd))
    else $error("answer without read");
  AST_OFFSET: assert property (moved(ADR_IND_ACC_OFFSET, 12'h000))
    else $error("offset read moved pointer");
  AST_ACC: assert property (req.wr && req.addr == ADR_WORKING_ACC
    |=> workingAcc == $past(req.wdata)) else $error("accumulator write lost");
  AST_BANK: assert property (req.wr && req.addr == ADR_BANK_SELECT
    |=> bankSelect == $past(req.wdata[3:0])) else $error("bank write lost");
endmodule // ind_ptr_properties
bind indirect_pointer_operand_access ind_ptr_properties u_props (
  .clock(clock), .srst(srst), .req(req), .rsp(rsp),
  .pointerZero(pointerZero), .workingAcc(workingAcc), .bankSelect(bankSelect));
`default_nettype wire

//--- tb/cpu_datapath_model.sv
// datapath side model: packs one access a cycle
// assumes the bench drives its inputs at clock edges
`timescale 1ns/1ps
`default_nettype none
module cpu_datapath_model (
  // access from the bench
  input  wire logic                   rd,
  input  wire logic                   wr,
  input  wire logic [11:0]            addr,
  input  wire logic [7:0]             wdata,
  // request to the register slice
  output var  ind_ptr_pkg::file_req_t req
);
  import ind_ptr_pkg::*;
  // rd with wr at one edge stays one access
  assign req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
endmodule // cpu_datapath_model
`default_nettype wire

//--- tb/indirect_pointer_operand_access_tb.sv
// bench for the register slice behind the datapath model
// assumes the checker is bound onto the slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module indirect_pointer_operand_access_tb;
  import ind_ptr_pkg::*;
  logic        clock, srst, rd, wr;
  logic [11:0] addr, pointerZero;
  logic [7:0]  wdata, workingAcc;
  logic [3:0]  bankSelect;
  file_req_t   req;
  file_rsp_t   rsp;
  int          fails = 0;
  int          total_checks = 0;
  cpu_datapath_model u_cpu (.rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .req(req));
  indirect_pointer_operand_access u_dut (.clock(clock), .srst(srst), .req(req), .rsp(rsp),
    .pointerZero(pointerZero), .workingAcc(workingAcc), .bankSelect(bankSelect));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ---------------------------------
  // scenarios
  // ---------------------------------
  // answer stands one cycle, so it is sampled at the falling edge
  task automatic put(input logic r, input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    rd    <= r;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clock);
  endtask
  task automatic look(input string n, input logic [11:0] a, input logic [7:0] e,
                      input logic [11:0] p);
    put(1'b1, 1'b0, a, 8'h00);
    `CHK("valid", 1'b1, rsp.valid)
    `CHK(n, e, rsp.rdata)
    `CHK("pointer", p, pointerZero)
  endtask
  task automatic check_reset();
    look("second ctl", ADR_INT_CTRL_SECOND, 8'hFF, 12'h000);
    look("third ctl", ADR_INT_CTRL_THIRD, 8'hC0, 12'h000);
  endtask
  task automatic check_modes();
    put(1'b0, 1'b1, ADR_BANK_SELECT, 8'h05);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_HIGH, 8'h01);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_LOW, 8'h00);
    put(1'b0, 1'b1, 12'h100, 8'hA5);
    put(1'b0, 1'b1, 12'h101, 8'h5A);
    put(1'b0, 1'b1, 12'h200, 8'h77);
    look("after up", ADR_IND_AFTER_UP, 8'hA5, 12'h101);
    look("plain", ADR_IND_PLAIN, 8'h5A, 12'h101);
    look("after down", ADR_IND_AFTER_DOWN, 8'h5A, 12'h100);
    look("before up", ADR_IND_BEFORE_UP, 8'h5A, 12'h101);
    put(1'b0, 1'b1, ADR_IND_PLAIN, 8'h3C);
    look("redirect", 12'h101, 8'h3C, 12'h101);
    put(1'b0, 1'b1, ADR_WORKING_ACC, 8'hFF);
    `CHK("acc", 8'hFF, workingAcc)
    look("offset", ADR_IND_ACC_OFFSET, 8'h77, 12'h101);
    `CHK("bank", 4'h5, bankSelect)
  endtask
  task automatic check_wrap();
    put(1'b0, 1'b1, ADR_POINTER_ZERO_HIGH, 8'hFF);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_LOW, 8'hFF);
    look("high byte", ADR_POINTER_ZERO_HIGH, 8'h0F, 12'hFFF);
    look("wrap", ADR_IND_AFTER_UP, 8'h00, 12'h000);
  endtask
  task automatic check_unimpl();
    put(1'b0, 1'b1, ADR_SFR_BASE, 8'hAA);
    look("unused low", ADR_SFR_BASE, 8'h00, 12'h000);
    look("unused high", 12'hFDF, 8'h00, 12'h000);
  endtask
  task automatic check_refuse();
    put(1'b0, 1'b1, ADR_POINTER_ZERO_HIGH, 8'h0F);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_LOW, 8'hEF);
    put(1'b0, 1'b1, ADR_IND_PLAIN, 8'h99);
    look("self aim", ADR_IND_PLAIN, 8'h00, 12'hFEF);
    look("self step", ADR_IND_AFTER_UP, 8'h00, 12'hFF0);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_LOW, 8'hE8);
    put(1'b0, 1'b1, ADR_IND_PLAIN, 8'h42);
    `CHK("acc via ptr", 8'h42, workingAcc)
    look("acc read", ADR_IND_PLAIN, 8'h42, 12'hFE8);
    put(1'b0, 1'b1, ADR_POINTER_ZERO_LOW, 8'hE9);
    put(1'b0, 1'b1, ADR_IND_AFTER_UP, 8'h30);
    `CHK("one update", 12'hF30, pointerZero)
  endtask
  task automatic check_rerun();
    put(1'b0, 1'b1, ADR_STACK_TOP_LOW, 8'h12);
    put(1'b0, 1'b1, 12'h020, 8'h6B);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    `CHK("reset ptr", 12'h000, pointerZero)
    `CHK("reset acc", 8'h00, workingAcc)
    `CHK("reset bank", 4'h0, bankSelect)
    `CHK("reset valid", 1'b0, rsp.valid)
    look("reset core", ADR_STACK_TOP_LOW, 8'h00, 12'h000);
    look("ram kept", 12'h020, 8'h6B, 12'h000);
  endtask
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {srst, rd, wr, addr, wdata} = {3'b100, 12'h000, 8'h00};
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    check_reset();
    check_modes();
    check_wrap();
    check_unimpl();
    check_refuse();
    check_rerun();
    print_verdict();
  end
endmodule // indirect_pointer_operand_access_tb
`default_nettype wire
